// [src/mmp_pkg.sv]
package mmp_pkg;

  // data-side byte map (15-bit location)
  localparam logic [14:0] WIN_BASE     = 15'h0000;
  localparam logic [14:0] REG_BASE     = 15'h4000;
  localparam logic [14:0] SYSREG_BASE  = 15'h4800;
  localparam logic [14:0] INFO_BASE    = 15'h5000;
  localparam logic [14:0] INFO_END     = 15'h5400;
  localparam logic [14:0] RAM_DATA_BASE = 15'h6c00;

  // program-side word map
  localparam logic [15:0] CODE_FLASH_END = 16'he000;
  localparam logic [15:0] CODE_RAM_BASE  = 16'hf600;

  // bit position of the size flag on the data address
  localparam int SIZE_BIT = 15;

  // ram protection
  localparam int SEG_COUNT = 160;
  localparam int SEG_SHIFT = 5;
  localparam int PERM_WORDS = 5;

  // ahb register offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] FAULT_OFS  = 8'h08;
  localparam logic [7:0] PERM_OFS   = 8'h10;

  // reset values
  localparam logic [2:0]   SECTION_RST = 3'h0;
  localparam logic [159:0] PERM_RST    = {160{1'b1}};

  typedef enum logic [2:0] {
    RG_NONE,
    RG_FLASH,
    RG_INFO,
    RG_REG,
    RG_RAM
  } mmp_region_type;

  typedef struct packed {
    logic        re;
    logic        we;
    logic [1:0]  be;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mmp_mreq_type;

  typedef struct packed {
    logic [159:0]   perm;
    logic [2:0]     section;
    logic           faultFlag;
    logic [14:0]    faultAddr;
    logic           faultByte;
    logic           unlockMeta;
    logic           unlockSync;
    logic           hselQ;
    logic           hwriteQ;
    logic [7:0]     haddrQ;
    logic [31:0]    hrdataQ;
    logic           dPend;
    mmp_region_type dRegion;
    logic           dByte;
    logic           dHigh;
    logic [15:0]    dRdataQ;
    logic           dRvalidQ;
    logic           pPend;
    mmp_region_type pRegion;
    logic [15:0]    pRdataQ;
    logic           pRvalidQ;
  } mmp_state_type;

  function automatic mmp_region_type data_region(input logic [14:0] loc);
    if (loc < REG_BASE)
      return RG_FLASH;
    else if (loc < INFO_BASE)
      return RG_REG;
    else if (loc < INFO_END)
      return RG_INFO;
    else if (loc >= RAM_DATA_BASE)
      return RG_RAM;
    else
      return RG_NONE;
  endfunction : data_region

  function automatic logic [15:0] pick_byte(input logic [15:0] w, input logic hi,
                                            input logic isByte);
    if (!isByte)
      return w;
    else
      return {8'h00, (hi ? w[15:8] : w[7:0])};
  endfunction : pick_byte

endpackage : mmp_pkg

// [src/mmp_memory_map_protection.sv]
`timescale 1ns/1ps
module mmp_memory_map_protection (
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  // core, program side
  input  wire logic                 pReq,
  input  wire logic [15:0]          pAddr,
  output logic [15:0]               pRdata,
  output logic                      pRvalid,
  // core, data side
  input  wire logic                 dReq,
  input  wire logic                 dWrite,
  input  wire logic [15:0]          dAddr,
  input  wire logic [15:0]          dWdata,
  input  wire logic                 sysMode,
  output logic [15:0]               dRdata,
  output logic                      dRvalid,
  output logic                      faultPulse,
  // debug serial port unlock pin
  input  wire logic                 dbgInfoUnlock,
  output logic                      infoProgEnable,
  // memories and register region
  output mmp_pkg::mmp_mreq_type     flashCodeReq,
  input  wire logic [15:0]          flashCodeRdata,
  output mmp_pkg::mmp_mreq_type     flashDataReq,
  input  wire logic [15:0]          flashDataRdata,
  output mmp_pkg::mmp_mreq_type     infoReq,
  input  wire logic [15:0]          infoRdata,
  output mmp_pkg::mmp_mreq_type     ramCodeReq,
  input  wire logic [15:0]          ramCodeRdata,
  output mmp_pkg::mmp_mreq_type     ramReq,
  input  wire logic [15:0]          ramRdata,
  output mmp_pkg::mmp_mreq_type     regReq,
  input  wire logic [15:0]          regRdata,
  // ahb-lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata
);

  mmp_pkg::mmp_state_type  q;
  mmp_pkg::mmp_state_type  n;

  logic [14:0]             dLoc;
  logic                    dIsByte;
  mmp_pkg::mmp_region_type dReg;
  logic [14:0]             ramOffWide;
  logic [12:0]             ramOff;
  logic [7:0]              seg;
  logic                    segAllowed;
  logic                    sysRegHit;
  logic                    blockPriv;
  logic                    refuseWrite;
  logic                    wrOk;
  logic [16:0]             winByte;
  logic [15:0]             ramCodeOff;
  mmp_pkg::mmp_region_type pReg;
  logic [1:0]              laneBe;
  logic [15:0]             laneData;
  logic                    ahbAccept;
  logic [15:0]             dWord;

  // data-side decode
  assign dLoc       = dAddr[14:0];
  assign dIsByte    = dAddr[mmp_pkg::SIZE_BIT];
  assign dReg       = mmp_pkg::data_region(dLoc);
  assign ramOffWide = dLoc - mmp_pkg::RAM_DATA_BASE;
  assign ramOff     = ramOffWide[12:0];
  assign seg        = ramOff[12:mmp_pkg::SEG_SHIFT];
  assign segAllowed = sysMode | q.perm[seg];
  assign sysRegHit  = (dLoc >= mmp_pkg::SYSREG_BASE) && (dLoc < mmp_pkg::INFO_BASE);
  assign winByte    = {q.section, dLoc[13:0]};

  // privilege check on writes
  assign blockPriv = dReq & dWrite & ~sysMode &
                     (((dReg == mmp_pkg::RG_RAM) & ~segAllowed) |
                      ((dReg == mmp_pkg::RG_REG) & sysRegHit));

  // flash and info page accept whole words only, info page needs unlock
  assign refuseWrite = dReq & dWrite &
                       ((((dReg == mmp_pkg::RG_FLASH) | (dReg == mmp_pkg::RG_INFO)) & dIsByte) |
                        ((dReg == mmp_pkg::RG_INFO) & ~q.unlockSync));
  assign wrOk       = dReq & dWrite & ~blockPriv & ~refuseWrite;
  assign faultPulse = blockPriv;

  // byte lanes for writes
  assign laneBe   = dIsByte ? (dLoc[0] ? 2'h2 : 2'h1) : 2'h3;
  assign laneData = dIsByte ? {dWdata[7:0], dWdata[7:0]} : dWdata;

  assign flashDataReq = '{re:    dReq & ~dWrite & (dReg == mmp_pkg::RG_FLASH),
                          we:    wrOk & (dReg == mmp_pkg::RG_FLASH),
                          be:    2'h3,
                          addr:  winByte[16:1],
                          wdata: dWdata};
  assign infoReq      = '{re:    dReq & ~dWrite & (dReg == mmp_pkg::RG_INFO),
                          we:    wrOk & (dReg == mmp_pkg::RG_INFO),
                          be:    2'h3,
                          addr:  {7'h00, dLoc[9:1]},
                          wdata: dWdata};
  assign ramReq       = '{re:    dReq & ~dWrite & (dReg == mmp_pkg::RG_RAM),
                          we:    wrOk & (dReg == mmp_pkg::RG_RAM),
                          be:    laneBe,
                          addr:  {4'h0, ramOff[12:1]},
                          wdata: laneData};
  assign regReq       = '{re:    dReq & ~dWrite & (dReg == mmp_pkg::RG_REG),
                          we:    wrOk & (dReg == mmp_pkg::RG_REG),
                          be:    laneBe,
                          addr:  {4'h0, dLoc[11:0]},
                          wdata: laneData};
  assign infoProgEnable = q.unlockSync;

  // program-side decode
  assign ramCodeOff = pAddr - mmp_pkg::CODE_RAM_BASE;
  assign pReg = (pAddr < mmp_pkg::CODE_FLASH_END) ? mmp_pkg::RG_FLASH :
                (pAddr >= mmp_pkg::CODE_RAM_BASE) ? mmp_pkg::RG_RAM : mmp_pkg::RG_NONE;

  assign flashCodeReq = '{re:    pReq & (pReg == mmp_pkg::RG_FLASH),
                          we:    1'b0,
                          be:    2'h3,
                          addr:  pAddr,
                          wdata: 16'h0000};
  assign ramCodeReq   = '{re:    pReq & (pReg == mmp_pkg::RG_RAM),
                          we:    1'b0,
                          be:    2'h3,
                          addr:  {4'h0, ramCodeOff[11:0]},
                          wdata: 16'h0000};

  // read return mux for the data side
  always_comb
  begin
    unique case (q.dRegion)
      mmp_pkg::RG_FLASH: dWord = flashDataRdata;
      mmp_pkg::RG_INFO:  dWord = infoRdata;
      mmp_pkg::RG_REG:   dWord = regRdata;
      mmp_pkg::RG_RAM:   dWord = ramRdata;
      default:           dWord = 16'h0000;
    endcase
  end

  assign ahbAccept = hsel & htrans[1] & hready;

  // next state
  always_comb
  begin
    n = q;

    // unlock pin synchroniser
    n.unlockMeta = dbgInfoUnlock;
    n.unlockSync = q.unlockMeta;

    // ahb data phase write
    if (q.hselQ && q.hwriteQ)
    begin
      if (q.haddrQ == mmp_pkg::CTRL_OFS)
        n.section = hwdata[2:0];
      if (q.haddrQ == mmp_pkg::STATUS_OFS && hwdata[0])
        n.faultFlag = 1'b0;
      for (int i = 0; i < mmp_pkg::PERM_WORDS; i++)
      begin
        if (q.haddrQ == mmp_pkg::PERM_OFS + 8'(4 * i))
          n.perm[i*32 +: 32] = hwdata;
      end
    end

    // fault capture, set wins over a same-cycle clear and then takes the new address
    if (blockPriv)
    begin
      if (!n.faultFlag)
      begin
        n.faultAddr = dLoc;
        n.faultByte = dIsByte;
      end
      n.faultFlag = 1'b1;
    end

    // ahb address phase
    if (hready)
    begin
      n.hselQ   = ahbAccept;
      n.hwriteQ = hwrite;
      n.haddrQ  = haddr[7:0];
    end
    if (ahbAccept && !hwrite)
    begin
      n.hrdataQ = 32'h0000_0000;
      if (haddr[31:8] == 24'h000000)
      begin
        if (haddr[7:0] == mmp_pkg::CTRL_OFS)
          n.hrdataQ = {29'h0, n.section};
        if (haddr[7:0] == mmp_pkg::STATUS_OFS)
          n.hrdataQ = {29'h0, sysMode, q.unlockSync, n.faultFlag};
        if (haddr[7:0] == mmp_pkg::FAULT_OFS)
          n.hrdataQ = {15'h0, n.faultByte, 1'b0, n.faultAddr};
        for (int i = 0; i < mmp_pkg::PERM_WORDS; i++)
        begin
          if (haddr[7:0] == mmp_pkg::PERM_OFS + 8'(4 * i))
            n.hrdataQ = n.perm[i*32 +: 32];
        end
      end
    end

    // data read pipeline
    n.dPend    = dReq & ~dWrite;
    n.dRegion  = dReg;
    n.dByte    = dIsByte;
    n.dHigh    = dLoc[0];
    n.dRvalidQ = q.dPend;
    if (q.dPend)
      n.dRdataQ = mmp_pkg::pick_byte(dWord, q.dHigh, q.dByte);

    // program read pipeline
    n.pPend    = pReq;
    n.pRegion  = pReg;
    n.pRvalidQ = q.pPend;
    if (q.pPend)
    begin
      unique case (q.pRegion)
        mmp_pkg::RG_FLASH: n.pRdataQ = flashCodeRdata;
        mmp_pkg::RG_RAM:   n.pRdataQ = ramCodeRdata;
        default:           n.pRdataQ = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q            <= '0;
      q.perm       <= mmp_pkg::PERM_RST;
      q.section    <= mmp_pkg::SECTION_RST;
      q.dRegion    <= mmp_pkg::RG_NONE;
      q.pRegion    <= mmp_pkg::RG_NONE;
    end
    else
    begin
      q <= n;
    end
  end

  assign pRdata    = q.pRdataQ;
  assign pRvalid   = q.pRvalidQ;
  assign dRdata    = q.dRdataQ;
  assign dRvalid   = q.dRvalidQ;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = q.hrdataQ;

endmodule : mmp_memory_map_protection

// [sim/mmp_mem_model.sv]
`timescale 1ns/1ps
module mmp_mem_model (
  input  wire logic                  ref_clk,
  input  wire mmp_pkg::mmp_mreq_type fcReq,
  input  wire mmp_pkg::mmp_mreq_type fdReq,
  input  wire mmp_pkg::mmp_mreq_type inReq,
  input  wire mmp_pkg::mmp_mreq_type rcReq,
  input  wire mmp_pkg::mmp_mreq_type rmReq,
  input  wire mmp_pkg::mmp_mreq_type rgReq,
  output logic [15:0]                fcData,
  output logic [15:0]                fdData,
  output logic [15:0]                inData,
  output logic [15:0]                rcData,
  output logic [15:0]                rmData,
  output logic [15:0]                rgData
);
  // whole word a cycle after re; idle bus flips so stale data never matches
  function automatic logic [15:0] nx(input mmp_pkg::mmp_mreq_type r, input logic [15:0] k,
                                     input logic [15:0] q);
    return r.re ? (r.addr ^ k) : ~q;
  endfunction : nx
  always_ff @(posedge ref_clk)
  begin
    fcData <= nx(fcReq, 16'h1111, fcData);
    fdData <= nx(fdReq, 16'h2222, fdData);
    inData <= nx(inReq, 16'h3333, inData);
    rcData <= nx(rcReq, 16'h4444, rcData);
    rmData <= nx(rmReq, 16'h5555, rmData);
    rgData <= nx(rgReq, 16'h6666, rgData);
  end
endmodule : mmp_mem_model

// [sim/mmp_checker_sva.sv]
`timescale 1ns/1ps
module mmp_checker (
  input wire logic                  ref_clk,
  input wire logic                  rst_n,
  input wire logic                  pReq,
  input wire logic [15:0]           pAddr,
  input wire logic                  pRvalid,
  input wire logic                  dReq,
  input wire logic                  dWrite,
  input wire logic [15:0]           dAddr,
  input wire logic                  sysMode,
  input wire logic                  dRvalid,
  input wire logic                  faultPulse,
  input wire logic                  infoProgEnable,
  input wire mmp_pkg::mmp_mreq_type flashCodeReq,
  input wire mmp_pkg::mmp_mreq_type flashDataReq,
  input wire mmp_pkg::mmp_mreq_type infoReq,
  input wire mmp_pkg::mmp_mreq_type ramCodeReq,
  input wire mmp_pkg::mmp_mreq_type ramReq,
  input wire mmp_pkg::mmp_mreq_type regReq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_rd; dReq && !dWrite; endsequence
  sequence s_wr; dReq && dWrite; endsequence
  sequence s_hole; dReq && dAddr[14:0] >= 15'h5400 && dAddr[14:0] < 15'h6c00; endsequence
  a_fetch_answer: assert property (pReq |-> ##2 pRvalid)
    else $error("fetch not answered");
  a_read_answer: assert property (s_rd |-> ##2 dRvalid)
    else $error("data read not answered");
  a_fault_cause: assert property (faultPulse |-> dReq && dWrite && !sysMode)
    else $error("fault without app write");
  a_sys_free: assert property (s_wr ##0 sysMode |-> !faultPulse)
    else $error("system write faulted");
  a_block_we: assert property (faultPulse |-> !ramReq.we && !regReq.we)
    else $error("blocked write reached target");
  a_info_lock: assert property (infoReq.we |-> infoProgEnable && !dAddr[15])
    else $error("info write while locked");
  a_hole_idle: assert property (s_hole |-> !(ramReq.re | infoReq.re | regReq.re
                                  | flashDataReq.re | ramReq.we | regReq.we))
    else $error("unmapped access reached memory");
  a_ram_read: assert property (s_rd ##0 (dAddr[14:0] >= 15'h6c00) |-> ramReq.re)
    else $error("ram read not issued");
  a_code_ram: assert property (pReq && pAddr >= 16'hf600 |->
                                 ramCodeReq.re && ramCodeReq.addr == pAddr - 16'hf600)
    else $error("ram fetch mapping wrong");
  a_code_flash: assert property (pReq && pAddr < 16'he000 |->
                                   flashCodeReq.re && flashCodeReq.addr == pAddr)
    else $error("flash fetch mapping wrong");
endmodule : mmp_checker
bind mmp_memory_map_protection mmp_checker u_chk (.ref_clk, .rst_n, .pReq, .pAddr, .pRvalid,
  .dReq, .dWrite, .dAddr, .sysMode, .dRvalid, .faultPulse, .infoProgEnable, .flashCodeReq,
  .flashDataReq, .infoReq, .ramCodeReq, .ramReq, .regReq);

// [sim/tb_memory_map_protection.sv]
`timescale 1ns/1ps
module tb_memory_map_protection;
  logic ref_clk = 1'b0, rst_n = 1'b0, pReq = 1'b0, dReq = 1'b0, dWrite = 1'b0;
  logic sysMode = 1'b0, dbgInfoUnlock = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [15:0] pAddr = 16'h0, dAddr = 16'h0, dWdata = 16'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, r;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [15:0] pRdata, dRdata, flashCodeRdata, flashDataRdata, infoRdata;
  logic [15:0] ramCodeRdata, ramRdata, regRdata;
  logic        pRvalid, dRvalid, faultPulse, infoProgEnable, hreadyout, hresp, hready;
  logic [31:0] hrdata;
  mmp_pkg::mmp_mreq_type flashCodeReq, flashDataReq, infoReq, ramCodeReq, ramReq, regReq;
  int          errTotal = 0, checksDone = 0;
  assign hready = hreadyout;
  always #12.5 ref_clk = ~ref_clk;
  mmp_memory_map_protection dut (.ref_clk, .rst_n, .pReq, .pAddr, .pRdata, .pRvalid, .dReq,
    .dWrite, .dAddr, .dWdata, .sysMode, .dRdata, .dRvalid, .faultPulse, .dbgInfoUnlock,
    .infoProgEnable, .flashCodeReq, .flashCodeRdata, .flashDataReq, .flashDataRdata, .infoReq,
    .infoRdata, .ramCodeReq, .ramCodeRdata, .ramReq, .ramRdata, .regReq, .regRdata, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata);
  mmp_mem_model mem (.ref_clk, .fcReq(flashCodeReq), .fdReq(flashDataReq), .inReq(infoReq),
    .rcReq(ramCodeReq), .rmReq(ramReq), .rgReq(regReq), .fcData(flashCodeRdata),
    .fdData(flashDataRdata), .inData(infoRdata), .rcData(ramCodeRdata), .rmData(ramRdata),
    .rgData(regRdata));
  task automatic testDone();
    $display("checks %0d mismatches %0d", checksDone, errTotal);
    if (errTotal == 0 && checksDone > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : testDone
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp)
    begin
      errTotal++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= w;
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'h0; hsel <= 1'b0; hwdata <= wd;
    do @(posedge ref_clk); while (hready !== 1'b1);
    r = hrdata;
  endtask : ahb
  // side 0 fetch, side 1 data read; answer looked at just after the edge that raises it
  task automatic acc(input logic side, input logic [15:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    if (side)
    begin
      dReq <= 1'b1;
      dWrite <= 1'b0;
      dAddr <= a;
    end
    else
    begin
      pReq <= 1'b1;
      pAddr <= a;
    end
    @(posedge ref_clk);
    pReq <= 1'b0;
    dReq <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk("read valid", 32'h1, {31'h0, side ? dRvalid : pRvalid});
    chk("read data", {16'h0, exp}, {16'h0, side ? dRdata : pRdata});
  endtask : acc
  task automatic dwr(input logic [15:0] a, input logic s, input logic we, input logic f);
    @(posedge ref_clk);
    dReq <= 1'b1; dWrite <= 1'b1; dAddr <= a; dWdata <= 16'ha5c3; sysMode <= s;
    #1 chk("write enable", {31'h0, we}, {31'h0, flashDataReq.we | infoReq.we | ramReq.we
                                         | regReq.we});
    chk("fault pulse", {31'h0, f}, {31'h0, faultPulse});
    @(posedge ref_clk);
    dReq <= 1'b0; dWrite <= 1'b0;
  endtask : dwr
  logic [15:0] fa [5] = '{16'h0000, 16'hdfff, 16'hf600, 16'hffff, 16'he000};
  logic [15:0] fe [5] = '{16'h1111, 16'hceee, 16'h4444, 16'h4dbb, 16'h0000};
  logic [15:0] da [8] = '{16'h0002, 16'h8003, 16'h8002, 16'h5002, 16'h4010, 16'h6000,
                          16'h6c04, 16'hffff};
  logic [15:0] de [8] = '{16'h2223, 16'h0022, 16'h0023, 16'h3332, 16'h6676, 16'h0000,
                          16'h5557, 16'h005c};
  initial
  begin
    #100us;
    errTotal++;
    testDone();
  end
  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) acc(1'b0, fa[i], fe[i]);
    $display("test fetch done");
    for (int i = 0; i < 8; i++) acc(1'b1, da[i], de[i]);
    ahb(1'b1, 8'h00, 32'h7);
    ahb(1'b0, 8'h00, 32'h0);
    chk("section", 32'h7, r);
    acc(1'b1, 16'h2002, 16'hd223);
    $display("test data map done");
    ahb(1'b1, 8'h10, 32'hffff_fffe);
    dwr(16'h6c00, 1'b0, 1'b0, 1'b1);
    dwr(16'h6c20, 1'b0, 1'b1, 1'b0);
    dwr(16'h6c00, 1'b1, 1'b1, 1'b0);
    ahb(1'b0, 8'h04, 32'h0);
    chk("status", 32'h5, r);
    ahb(1'b0, 8'h08, 32'h0);
    chk("fault address", 32'h6c00, r);
    ahb(1'b1, 8'h04, 32'h1);
    ahb(1'b0, 8'h04, 32'h0);
    chk("status cleared", 32'h4, r);
    dwr(16'h4800, 1'b0, 1'b0, 1'b1);
    ahb(1'b0, 8'h08, 32'h0);
    chk("fault address", 32'h4800, r);
    dwr(16'h4800, 1'b1, 1'b1, 1'b0);
    dwr(16'h4000, 1'b0, 1'b1, 1'b0);
    $display("test protection done");
    dwr(16'h5000, 1'b1, 1'b0, 1'b0);
    dwr(16'h0000, 1'b1, 1'b1, 1'b0);
    dwr(16'h8000, 1'b1, 1'b0, 1'b0);
    dbgInfoUnlock <= 1'b1;
    for (int i = 0; i < 6 && infoProgEnable !== 1'b1; i++) @(posedge ref_clk);
    chk("unlock", 32'h1, {31'h0, infoProgEnable});
    dwr(16'h5000, 1'b1, 1'b1, 1'b0);
    dwr(16'hd000, 1'b1, 1'b0, 1'b0);
    dwr(16'h6000, 1'b0, 1'b0, 1'b0);
    ahb(1'b0, 8'h40, 32'h0);
    chk("unmapped register", 32'h0, r);
    chk("okay response", 32'h0, {30'h0, hresp, ~hreadyout});
    $display("test info and holes done");
    testDone();
  end
endmodule : tb_memory_map_protection
